// file: design/cls_pkg.sv
// Purpose: Shared constants and types for the cold load setting switcher.
// Assumes: 32-bit classic Wishbone register port, byte addresses.
// Notes: Timer values count processing ticks; all ones means infinity.
package cls_pkg;
    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0] CLS_CTRL_OFS = 8'h00;
    localparam logic [7:0] CLS_OPEN_TIME_OFS = 8'h04;
    localparam logic [7:0] CLS_ACTIVE_TIME_OFS = 8'h08;
    localparam logic [7:0] CLS_STOP_TIME_OFS = 8'h0C;
    localparam logic [7:0] CLS_DYN_PICKUP_OFS = 8'h10;
    localparam logic [7:0] CLS_DYN_DELAY_OFS = 8'h14;
    localparam logic [7:0] CLS_STATUS_OFS = 8'h18;

    // ************************************************************
    // Fields and reset values
    // ************************************************************
    localparam int CLS_CTRL_EN_BIT = 0;
    localparam int CLS_CTRL_COND_LSB = 1;
    localparam int CLS_TIME_W = 16;
    localparam logic [15:0] CLS_TIME_INF = 16'hFFFF;
    localparam logic CLS_EN_RST = 1'b0;
    localparam logic [1:0] CLS_COND_RST = 2'h0;
    localparam logic [15:0] CLS_OPEN_TIME_RST = 16'h0064;
    localparam logic [15:0] CLS_ACTIVE_TIME_RST = 16'h0E10;
    localparam logic [15:0] CLS_STOP_TIME_RST = 16'hFFFF;
    localparam logic [15:0] CLS_DYN_PICKUP_RST = 16'h0000;
    localparam logic [15:0] CLS_DYN_DELAY_RST = 16'h0000;

    typedef enum logic [1:0] {
        CLS_NO_CURRENT,
        CLS_BREAKER,
        CLS_RECLOSE,
        CLS_COND_RSVD
    } cls_start_type;

    typedef enum logic [2:0] {
        CLS_PU_WAIT,
        CLS_IDLE,
        CLS_OPEN_WAIT,
        CLS_COLD_DYN,
        CLS_ACTIVE_RUN,
        CLS_PICKUP_HOLD,
        CLS_EXT_DYN
    } cls_state_type;
endpackage : cls_pkg

// file: design/cls_sync.sv
// Purpose: Two-stage synchroniser for the binary inputs.
// Assumes: Inputs are slow levels from pins.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ps
`default_nettype none
module cls_sync #(
    parameter int W = 5
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    import cls_pkg::*;

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } cls_sync_type;

    cls_sync_type q, d;

    always_comb
    begin
        d.s1 = async_in;
        d.s2 = q.s1;
        if (!rst_n)
        begin
            d = '0;
        end
    end

    always_ff @(posedge clock)
    begin
        q <= d;
    end

    assign sync_out = q.s2;
endmodule : cls_sync
`default_nettype wire

// file: design/cls_timer.sv
// Purpose: Tick counter compared against a configured duration.
// Assumes: tick_in is a one-cycle pulse on the same clock.
// Notes: A limit of all ones never expires; dropping run clears the count.
`timescale 1ns/1ps
`default_nettype none
module cls_timer (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic run,
    input wire logic tick_in,
    input wire logic [cls_pkg::CLS_TIME_W-1:0] limit,
    output logic expired,
    output logic [cls_pkg::CLS_TIME_W-1:0] count
);
    import cls_pkg::*;

    typedef struct packed {
        logic [CLS_TIME_W-1:0] cnt;
    } cls_timer_type;

    cls_timer_type q, d;

    // Infinity never expires even if the count saturates
    assign expired = run && (limit != CLS_TIME_INF) && (q.cnt >= limit);
    assign count = q.cnt;

    always_comb
    begin
        d = q;
        if (!run || !rst_n)
        begin
            d.cnt = '0;
        end
        else if (tick_in && !expired && q.cnt != CLS_TIME_INF)
        begin
            d.cnt = q.cnt + 16'h0001;
        end
    end

    always_ff @(posedge clock)
    begin
        q <= d;
    end

    timer_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
        !run |=> (q.cnt == 16'h0000)) else $error("timer not cleared");
endmodule : cls_timer
`default_nettype wire

// file: design/cls_switcher.sv
// Purpose: Decides when overcurrent elements use the dynamic setting set.
// Assumes: tick_in, reclose_ready_sig, pickup and dropout inputs are on clock.
// Notes: Registers over classic Wishbone; the five breaker, current, force and block pin inputs are synchronised.
//
// Implementation choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module cls_switcher (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic tick_in,
    input wire logic breaker_open_in,
    input wire logic curr_above_min_in,
    input wire logic dyn_set_force_in,
    input wire logic dyn_set_block_in,
    input wire logic stop_timer_block_in,
    input wire logic reclose_ready_sig,
    input wire logic elem_pickup_in,
    input wire logic [3:0] dropout_cond_in,
    input wire logic [cls_pkg::CLS_TIME_W-1:0] normal_pickup_in,
    input wire logic [cls_pkg::CLS_TIME_W-1:0] normal_delay_in,
    output logic [cls_pkg::CLS_TIME_W-1:0] pickup_out,
    output logic [cls_pkg::CLS_TIME_W-1:0] delay_out,
    output logic dyn_set_sel,
    output logic elem_timer_restart
);
    import cls_pkg::*;

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        cls_state_type st;
        logic dyn;
        logic restart;
        logic enable;
        cls_start_type cond;
        logic [CLS_TIME_W-1:0] open_time;
        logic [CLS_TIME_W-1:0] active_time;
        logic [CLS_TIME_W-1:0] stop_time;
        logic [CLS_TIME_W-1:0] dyn_pickup;
        logic [CLS_TIME_W-1:0] dyn_delay;
        logic [CLS_TIME_W-1:0] pickup;
        logic [CLS_TIME_W-1:0] delay;
        logic ack;
        logic [31:0] rdata;
    } cls_core_type;

    cls_core_type q, d;

    function automatic logic [15:0] cls_merge(
        input logic [15:0] old,
        input logic [31:0] wdata,
        input logic [3:0] sel
    );
        logic [15:0] res;
        res = old;
        if (sel[0])
        begin
            res[7:0] = wdata[7:0];
        end
        if (sel[1])
        begin
            res[15:8] = wdata[15:8];
        end
        return res;
    endfunction : cls_merge

    function automatic logic cls_is_dyn(input cls_state_type s);
        return (s == CLS_COLD_DYN) || (s == CLS_ACTIVE_RUN) ||
               (s == CLS_PICKUP_HOLD) || (s == CLS_EXT_DYN);
    endfunction : cls_is_dyn

    // ************************************************************
    // Input synchronisation and conditions
    // ************************************************************
    logic [4:0] pins_s;
    logic brk_open_s;
    logic cur_above_s;
    logic force_s;
    logic block_s;
    logic stop_block_s;
    logic deenerg;
    logic ext_req;
    logic func_ok;
    logic below_normal;
    logic open_run;
    logic active_run;
    logic stop_run;
    logic open_exp;
    logic active_exp;
    logic stop_exp;
    logic bus_req;
    logic bus_wr;

    cls_sync #(
        .W(5)
    ) u_sync (
        .clock(clock),
        .rst_n(rst_n),
        .async_in({stop_timer_block_in, dyn_set_block_in, dyn_set_force_in,
                   curr_above_min_in, breaker_open_in}),
        .sync_out(pins_s)
    );

    assign brk_open_s = pins_s[0];
    assign cur_above_s = pins_s[1];
    assign force_s = pins_s[2];
    assign block_s = pins_s[3];
    assign stop_block_s = pins_s[4];

    always_comb
    begin
        unique case (q.cond)
            CLS_BREAKER: deenerg = brk_open_s;
            CLS_NO_CURRENT: deenerg = !cur_above_s;
            default: deenerg = 1'b0;
        endcase
    end

    assign ext_req = force_s || (q.cond == CLS_RECLOSE && reclose_ready_sig);
    assign func_ok = q.enable && !block_s;
    assign below_normal = |dropout_cond_in;

    // ************************************************************
    // Timers
    // ************************************************************
    // Power-up wait also runs the open timer, but its expiry is ignored
    assign open_run = func_ok && (q.st == CLS_OPEN_WAIT || q.st == CLS_PU_WAIT);
    assign active_run = func_ok && (q.st == CLS_ACTIVE_RUN);
    assign stop_run = active_run && below_normal && !stop_block_s &&
                      (q.stop_time != CLS_TIME_INF);

    cls_timer u_open_tmr (
        .clock(clock),
        .rst_n(rst_n),
        .run(open_run),
        .tick_in(tick_in),
        .limit(q.open_time),
        .expired(open_exp),
        .count()
    );

    cls_timer u_active_tmr (
        .clock(clock),
        .rst_n(rst_n),
        .run(active_run),
        .tick_in(tick_in),
        .limit(q.active_time),
        .expired(active_exp),
        .count()
    );

    cls_timer u_stop_tmr (
        .clock(clock),
        .rst_n(rst_n),
        .run(stop_run),
        .tick_in(tick_in),
        .limit(q.stop_time),
        .expired(stop_exp),
        .count()
    );

    // ************************************************************
    // Sequencer and register port
    // ************************************************************
    assign bus_req = wb_cyc_i && wb_stb_i;
    // Writes land on the edge where the master sees ack
    assign bus_wr = bus_req && wb_we_i && q.ack;

    always_comb
    begin
        d = q;
        d.restart = 1'b0;
        if (!func_ok)
        begin
            // A fault in progress must fall back to normal element delays
            d.restart = cls_is_dyn(q.st) && elem_pickup_in;
            d.st = CLS_IDLE;
            // Enable comes from software after reset, so power-up wait must outlast it
            if (q.st == CLS_PU_WAIT && !q.enable && !block_s)
            begin
                d.st = CLS_PU_WAIT;
            end
        end
        else if (ext_req)
        begin
            d.st = CLS_EXT_DYN;
        end
        else
        begin
            unique case (q.st)
                CLS_PU_WAIT:
                begin
                    if (!deenerg)
                    begin
                        d.st = CLS_IDLE;
                    end
                end
                CLS_IDLE:
                begin
                    if (deenerg)
                    begin
                        d.st = CLS_OPEN_WAIT;
                    end
                end
                CLS_OPEN_WAIT:
                begin
                    if (!deenerg)
                    begin
                        d.st = CLS_IDLE;
                    end
                    else if (open_exp)
                    begin
                        d.st = CLS_COLD_DYN;
                    end
                end
                CLS_COLD_DYN:
                begin
                    if (!deenerg)
                    begin
                        d.st = CLS_ACTIVE_RUN;
                    end
                end
                CLS_ACTIVE_RUN:
                begin
                    if (deenerg)
                    begin
                        d.st = CLS_COLD_DYN;
                    end
                    else if (active_exp || stop_exp)
                    begin
                        d.st = elem_pickup_in ? CLS_PICKUP_HOLD : CLS_IDLE;
                    end
                end
                CLS_PICKUP_HOLD:
                begin
                    if (!elem_pickup_in)
                    begin
                        d.st = CLS_IDLE;
                    end
                end
                CLS_EXT_DYN:
                begin
                    d.st = CLS_IDLE;
                end
            endcase
        end
        d.dyn = cls_is_dyn(d.st);

        d.ack = bus_req && !q.ack;
        d.rdata = '0;
        if (bus_req && !q.ack && !wb_we_i)
        begin
            unique case (wb_adr_i)
                CLS_CTRL_OFS: d.rdata = {29'h0000_0000, q.cond, q.enable};
                CLS_OPEN_TIME_OFS: d.rdata = {16'h0000, q.open_time};
                CLS_ACTIVE_TIME_OFS: d.rdata = {16'h0000, q.active_time};
                CLS_STOP_TIME_OFS: d.rdata = {16'h0000, q.stop_time};
                CLS_DYN_PICKUP_OFS: d.rdata = {16'h0000, q.dyn_pickup};
                CLS_DYN_DELAY_OFS: d.rdata = {16'h0000, q.dyn_delay};
                CLS_STATUS_OFS: d.rdata = {25'h000_0000, q.st, stop_run, active_run, open_run, q.dyn};
                default: d.rdata = '0;
            endcase
        end
        if (bus_wr)
        begin
            unique case (wb_adr_i)
                CLS_CTRL_OFS:
                begin
                    if (wb_sel_i[0])
                    begin
                        d.enable = wb_dat_i[CLS_CTRL_EN_BIT];
                        d.cond = cls_start_type'(wb_dat_i[CLS_CTRL_COND_LSB +: 2]);
                    end
                end
                CLS_OPEN_TIME_OFS: d.open_time = cls_merge(q.open_time, wb_dat_i, wb_sel_i);
                CLS_ACTIVE_TIME_OFS: d.active_time = cls_merge(q.active_time, wb_dat_i, wb_sel_i);
                CLS_STOP_TIME_OFS: d.stop_time = cls_merge(q.stop_time, wb_dat_i, wb_sel_i);
                CLS_DYN_PICKUP_OFS: d.dyn_pickup = cls_merge(q.dyn_pickup, wb_dat_i, wb_sel_i);
                CLS_DYN_DELAY_OFS: d.dyn_delay = cls_merge(q.dyn_delay, wb_dat_i, wb_sel_i);
                default: d.rdata = '0;
            endcase
        end
        // Taken after the bus write so a new dynamic value applies on the same edge
        d.pickup = d.dyn ? d.dyn_pickup : normal_pickup_in;
        d.delay = d.dyn ? d.dyn_delay : normal_delay_in;

        if (!rst_n)
        begin
            d = '0;
            d.st = CLS_PU_WAIT;
            d.enable = CLS_EN_RST;
            d.cond = cls_start_type'(CLS_COND_RST);
            d.open_time = CLS_OPEN_TIME_RST;
            d.active_time = CLS_ACTIVE_TIME_RST;
            d.stop_time = CLS_STOP_TIME_RST;
            d.dyn_pickup = CLS_DYN_PICKUP_RST;
            d.dyn_delay = CLS_DYN_DELAY_RST;
        end
    end

    always_ff @(posedge clock)
    begin
        q <= d;
    end

    assign wb_ack_o = q.ack;
    assign wb_dat_o = q.rdata;
    assign pickup_out = q.pickup;
    assign delay_out = q.delay;
    assign dyn_set_sel = q.dyn;
    assign elem_timer_restart = q.restart;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    sequence s_free;
        func_ok && !ext_req;
    endsequence

    sequence s_active_end;
        q.st == CLS_ACTIVE_RUN && !deenerg && !elem_pickup_in;
    endsequence

    func_off_a: assert property (!q.enable |=> !dyn_set_sel) else $error("dynamic set while off");
    block_normal_a: assert property (block_s |=> !dyn_set_sel && q.st == CLS_IDLE)
        else $error("block did not restore normal");
    open_first_a: assert property ($rose(dyn_set_sel) && q.st == CLS_COLD_DYN |-> $past(open_exp))
        else $error("dynamic set before open time");
    force_dyn_a: assert property (force_s && func_ok |=> dyn_set_sel && q.st == CLS_EXT_DYN)
        else $error("force ignored");
    reclose_dyn_a: assert property (q.cond == CLS_RECLOSE && reclose_ready_sig && func_ok |=> dyn_set_sel)
        else $error("reclose ready ignored");
    ext_drop_a: assert property (q.st == CLS_EXT_DYN ##0 s_free |=> !dyn_set_sel)
        else $error("external drop kept dynamic set");
    active_end_a: assert property (s_active_end ##0 s_free ##0 active_exp |=> !dyn_set_sel)
        else $error("active time did not restore normal");
    stop_end_a: assert property (s_active_end ##0 s_free ##0 stop_exp |=> !dyn_set_sel)
        else $error("stop time did not end early");
    stop_hold_a: assert property (stop_block_s || q.stop_time == CLS_TIME_INF |-> !stop_run && !stop_exp)
        else $error("stop timer not held");
    pickup_hold_a: assert property (q.st == CLS_PICKUP_HOLD && elem_pickup_in ##0 s_free |=> dyn_set_sel)
        else $error("pickup hold released early");
    powerup_norm_a: assert property (q.st == CLS_PU_WAIT |-> !dyn_set_sel ##1 (q.st != CLS_COLD_DYN))
        else $error("power-up applied dynamic set");
    restart_pulse_a: assert property (elem_timer_restart |-> !dyn_set_sel ##1 !elem_timer_restart)
        else $error("restart pulse malformed");
    sel_pickup_a: assert property (dyn_set_sel |-> pickup_out == q.dyn_pickup && delay_out == q.dyn_delay)
        else $error("dynamic values not applied");
    bus_ack_a: assert property (bus_req && !q.ack |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus answer malformed");
endmodule : cls_switcher
`default_nettype wire

// file: sim/cls_far_model.sv
// Purpose: Far-side model of breaker auxiliary contacts and overcurrent elements.
// Assumes: Commands from the bench change just after a rising clock edge.
// Notes: The aux contact lags its command, so the switcher never sees an instant answer.
`timescale 1ns/1ps
`default_nettype none
module cls_far_model #(
    parameter int AUX_LAG = 3,
    parameter logic [15:0] NORM_PU = 16'h0200,
    parameter logic [15:0] NORM_DLY = 16'h0030
) (
    input wire logic clock,
    input wire logic open_cmd,
    input wire logic load_cmd,
    input wire logic fault_cmd,
    input wire logic [3:0] drop_mask,
    input wire logic elem_timer_restart,
    output logic breaker_open_in,
    output logic curr_above_min_in,
    output logic elem_pickup_in,
    output logic [3:0] dropout_cond_in,
    output logic [15:0] normal_pickup_in,
    output logic [15:0] normal_delay_in,
    output logic [7:0] restart_cnt
);
    logic [7:0] lag_q;

    initial
    begin
        lag_q = 8'hFF;
        breaker_open_in = 1'b1;
        curr_above_min_in = 1'b0;
        elem_pickup_in = 1'b0;
        dropout_cond_in = 4'h0;
        restart_cnt = 8'h00;
    end

    assign normal_pickup_in = NORM_PU;
    assign normal_delay_in = NORM_DLY;

    // Load current flows only through a closed breaker
    always @(posedge clock)
    begin
        lag_q <= {lag_q[6:0], open_cmd};
        breaker_open_in <= lag_q[AUX_LAG-1];
        curr_above_min_in <= load_cmd & ~lag_q[AUX_LAG-1];
        elem_pickup_in <= fault_cmd;
        dropout_cond_in <= (load_cmd & ~fault_cmd) ? drop_mask : 4'h0;
        restart_cnt <= restart_cnt + {7'h00, elem_timer_restart};
    end
endmodule : cls_far_model
`default_nettype wire

// file: sim/cls_switcher_tb.sv
// Purpose: Self-checking bench for the cold load setting switcher.
// Assumes: Tick every 4 clocks; timer values are written small.
// Notes: Bus answers are taken at the rising edge that shows ack; levels are watched at falling edges.
`timescale 1ns/1ps
`default_nettype none
module cls_switcher_tb;
    import cls_pkg::*;
    localparam logic [15:0] NORM_PU = 16'h0200;
    localparam logic [15:0] NORM_DLY = 16'h0030;
    localparam int LIMIT = 20000;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, tick = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0, drop_mask = 4'h8, drop;
    logic [31:0] wdat = 32'h0000_0000, rdat, q;
    logic force_in = 1'b0, block_in = 1'b0, stop_blk = 1'b0, recl = 1'b0;
    logic open_cmd = 1'b1, load_cmd = 1'b1, fault_cmd = 1'b0;
    logic bo, cam, pick, dyn, restart;
    logic [15:0] npu, ndly, pu_out, dly_out;
    logic [7:0] rcnt;
    int cycles = 0;
    int n_errors = 0;
    int check_count = 0;

    cls_switcher dut_u (.clock(clock), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .tick_in(tick),
        .breaker_open_in(bo), .curr_above_min_in(cam), .dyn_set_force_in(force_in),
        .dyn_set_block_in(block_in), .stop_timer_block_in(stop_blk), .reclose_ready_sig(recl),
        .elem_pickup_in(pick), .dropout_cond_in(drop), .normal_pickup_in(npu), .normal_delay_in(ndly),
        .pickup_out(pu_out), .delay_out(dly_out), .dyn_set_sel(dyn), .elem_timer_restart(restart));

    cls_far_model #(.NORM_PU(NORM_PU), .NORM_DLY(NORM_DLY)) far_u (.clock(clock), .open_cmd(open_cmd),
        .load_cmd(load_cmd), .fault_cmd(fault_cmd), .drop_mask(drop_mask), .elem_timer_restart(restart),
        .breaker_open_in(bo), .curr_above_min_in(cam), .elem_pickup_in(pick), .dropout_cond_in(drop),
        .normal_pickup_in(npu), .normal_delay_in(ndly), .restart_cnt(rcnt));

    // ************************************************************
    // Clock, tick and timeout
    // ************************************************************
    always #12.5 clock = ~clock;

    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        tick <= (cycles % 4 == 3);
        if (cycles == LIMIT)
        begin
            n_errors = n_errors + 1;
            final_report();
        end
    end

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : final_report

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // Classic single cycle; the request stands until ack is sampled at a rising edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clock);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hF;
        i = 0;
        do
        begin
            @(posedge clock);
            i++;
        end while (ack !== 1'b1);
        check("wb_ack_o latency", 32'h0000_0002, i);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : wb

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0000_0000);
        check("register read", exp, q);
    endtask : rd_chk

    task automatic wait_dyn(input logic exp, input int lim);
        int i;
        i = 0;
        do
        begin
            @(negedge clock);
            i++;
        end while (dyn !== exp && i < lim);
        check("dyn_set_sel", {31'h0, exp}, {31'h0, dyn});
    endtask : wait_dyn

    task automatic hold_dyn(input logic exp, input int n);
        logic bad;
        bad = 1'b0;
        repeat (n)
        begin
            @(negedge clock);
            if (dyn !== exp)
                bad = 1'b1;
        end
        check("dyn_set_sel held", 32'h0000_0000, {31'h0, bad});
    endtask : hold_dyn

    // ************************************************************
    // Tests
    // ************************************************************
    logic [7:0] ra [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h1C};
    logic [31:0] rv [7] = '{32'h0000_0000, 32'h0000_0064, 32'h0000_0E10, 32'h0000_FFFF,
        32'h0000_0000, 32'h0000_0000, 32'h0000_0000};

    initial
    begin
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        for (int k = 0; k < 7; k++)
            rd_chk(ra[k], rv[k]);
        wb(1'b1, 8'h04, 32'h0000_0008);
        wb(1'b1, 8'h08, 32'h0000_0008);
        wb(1'b1, 8'h10, 32'h0000_1234);
        wb(1'b1, 8'h14, 32'h0000_5678);
        wb(1'b1, 8'h00, 32'h0000_0003);
        rd_chk(8'h00, 32'h0000_0003);
        hold_dyn(1'b0, 80);
        @(posedge clock) open_cmd <= 1'b0;
        hold_dyn(1'b0, 40);
        $display("power-up test done");

        @(posedge clock) open_cmd <= 1'b1;
        hold_dyn(1'b0, 20);
        wait_dyn(1'b1, 60);
        repeat (2) @(negedge clock);
        check("pickup_out", 32'h0000_1234, {16'h0, pu_out});
        check("delay_out", 32'h0000_5678, {16'h0, dly_out});
        @(posedge clock) open_cmd <= 1'b0;
        hold_dyn(1'b1, 16);
        wait_dyn(1'b0, 60);
        repeat (2) @(negedge clock);
        check("pickup_out", {16'h0, NORM_PU}, {16'h0, pu_out});
        check("delay_out", {16'h0, NORM_DLY}, {16'h0, dly_out});
        $display("breaker cold load test done");

        @(posedge clock) open_cmd <= 1'b1;
        wait_dyn(1'b1, 80);
        @(posedge clock) fault_cmd <= 1'b1;
        open_cmd <= 1'b0;
        hold_dyn(1'b1, 100);
        @(posedge clock) fault_cmd <= 1'b0;
        wait_dyn(1'b0, 20);
        $display("pickup hold test done");

        wb(1'b1, 8'h08, 32'h0000_0100);
        wb(1'b1, 8'h0C, 32'h0000_0004);
        @(posedge clock) stop_blk <= 1'b1;
        open_cmd <= 1'b1;
        wait_dyn(1'b1, 80);
        @(posedge clock) open_cmd <= 1'b0;
        hold_dyn(1'b1, 60);
        @(posedge clock) stop_blk <= 1'b0;
        wait_dyn(1'b0, 60);
        $display("stop time test done");

        @(posedge clock) open_cmd <= 1'b1;
        wait_dyn(1'b1, 80);
        @(posedge clock) fault_cmd <= 1'b1;
        repeat (3) @(posedge clock);
        block_in <= 1'b1;
        wait_dyn(1'b0, 8);
        // The far model counts the pulse on the edge after it stands
        @(negedge clock);
        check("restart pulses", 32'h0000_0001, {24'h0, rcnt});
        @(posedge clock) open_cmd <= 1'b0;
        fault_cmd <= 1'b0;
        repeat (10) @(posedge clock);
        block_in <= 1'b0;
        hold_dyn(1'b0, 60);
        $display("block test done");

        wb(1'b1, 8'h00, 32'h0000_0001);
        @(posedge clock) load_cmd <= 1'b0;
        drop_mask <= 4'h2;
        hold_dyn(1'b0, 20);
        wait_dyn(1'b1, 60);
        @(posedge clock) load_cmd <= 1'b1;
        wait_dyn(1'b0, 80);
        $display("no-current test done");

        @(posedge clock) force_in <= 1'b1;
        wait_dyn(1'b1, 6);
        @(posedge clock) fault_cmd <= 1'b1;
        force_in <= 1'b0;
        wait_dyn(1'b0, 6);
        @(posedge clock) fault_cmd <= 1'b0;
        wb(1'b1, 8'h00, 32'h0000_0005);
        @(posedge clock) recl <= 1'b1;
        wait_dyn(1'b1, 4);
        @(posedge clock) recl <= 1'b0;
        wait_dyn(1'b0, 4);
        $display("force and reclose test done");

        wb(1'b1, 8'h00, 32'h0000_0007);
        rd_chk(8'h00, 32'h0000_0007);
        @(posedge clock) open_cmd <= 1'b1;
        hold_dyn(1'b0, 80);
        wb(1'b1, 8'h00, 32'h0000_0002);
        @(posedge clock) force_in <= 1'b1;
        hold_dyn(1'b0, 80);
        @(posedge clock) force_in <= 1'b0;
        $display("mode and disable test done");
        final_report();
    end
endmodule : cls_switcher_tb
`default_nettype wire
